// >>> core/pfdiv_top.sv
// Reference and feedback dividers with input select and Avalon-MM registers
// How it works
// - Feedback divider counts only oscillator input edges
// - Distribution gets auxiliary input unless select cleared
// - Reference divider: 14-bit, ratio 1 to 16383
// - Reference ratio zero divides by one
// - Reference ratio split six high, eight low
// - Divided reference drives first detector input
// - Feedback: 3-bit prescaler, 6-bit A, 13-bit B
// - Prescaler codes select fixed or dual modulus
// - Fixed-divide modes ignore the A counter
// - Bypass bit set forces B of one
// - B resets to zero, software must program
// - Dedicated bit resets only prescaler, A and B
// - Shared bit holds reference, A, B reset
// - Feedback ratio equals P times B plus A
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/100ps
`include "pfdiv_regs.svh"
module pfdiv_top
	import pfdiv_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        loop_source_input,
	input  wire logic        oscillator_feedback_input,
	input  wire logic        auxiliary_clock_input,
	output logic             ref_pfd_pulse,
	output logic             fb_pfd_pulse,
	output logic             dist_clock_out
);

	// ********************************
	// Declarations
	// ********************************
	pfdiv_bus_state_t bus_state_reg;     // Avalon answer phase
	logic             bus_req;           // Read or write pending
	logic             wr_take;           // Write commits this edge
	logic [7:0]       word_idx;          // Register index from byte address
	logic [7:0]       rd_next;           // Read mux result
	logic             input_sel_reg;     // 1: auxiliary input, 0: oscillator input
	logic [13:0]      ref_div_reg;       // Programmed reference ratio
	logic [2:0]       pre_mode_reg;      // Prescaler mode code
	logic             b_bypass_reg;      // B counter bypass
	logic [5:0]       a_count_reg;       // Programmed A value
	logic [12:0]      b_count_reg;       // Programmed B value
	logic             shared_rst_reg;    // Holds reference, A and B counters
	logic             ab_rst_reg;        // Holds prescaler, A and B counters only
	logic             ref_in_d_reg;      // Previous reference level
	logic             osc_in_d_reg;      // Previous oscillator level
	logic             ref_tick;          // Reference rising edge
	logic             osc_tick;          // Oscillator rising edge
	pfdiv_cnt_t       ref_mod_sh_reg;    // Reference ratio in use
	logic             ref_load_reg;      // First reference period pending
	logic [5:0]       p_sh_reg;          // Prescaler modulus P in use
	logic             dual_sh_reg;       // Dual-modulus mode in use
	logic [5:0]       a_sh_reg;          // A value in use
	pfdiv_cnt_t       b_mod_sh_reg;      // Effective B in use
	logic [5:0]       a_left_reg;        // Remaining P+1 cycles this period
	logic             fb_load_reg;       // First feedback period pending
	logic             fb_clear;          // Feedback chain held in reset
	logic             fb_period_end;     // Feedback divider wraps this edge
	logic [5:0]       p_next;            // Decoded P from mode register
	logic             dual_next;         // Decoded mode kind
	pfdiv_cnt_t       b_mod_next;        // Decoded effective B

	pfdiv_cnt_if ref_cif ();             // Reference divider
	pfdiv_cnt_if pre_cif ();             // Prescaler
	pfdiv_cnt_if b_cif   ();             // B counter

	// ********************************
	// Avalon-MM slave
	// ********************************
	assign bus_req         = avs_read | avs_write;
	assign word_idx        = avs_address[9:2];
	// Wait one cycle so read data can come from a flip-flop
	assign avs_waitrequest = bus_req & (bus_state_reg == BUS_IDLE);
	assign wr_take         = avs_write & avs_byteenable[0] & (bus_state_reg == BUS_ACK);

	// Answer phase: idle, then one acknowledge cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bus_state_reg <= BUS_IDLE;
		end else begin
			case (bus_state_reg)
				BUS_IDLE: bus_state_reg <= bus_req ? BUS_ACK : BUS_IDLE;
				BUS_ACK:  bus_state_reg <= BUS_IDLE;
				default:  bus_state_reg <= BUS_IDLE;
			endcase
		end
	end

	// Read mux; unmapped indices read zero
	always_comb begin
		rd_next = 8'h00;
		case (word_idx)
			`PFDIV_IDX_STATUS:    rd_next = {3'h0, shared_rst_reg | ab_rst_reg, fb_load_reg,
				ref_load_reg, dual_sh_reg, b_count_reg == 13'h0000};
			`PFDIV_IDX_A_COUNT:   rd_next = {2'h0, a_count_reg};
			`PFDIV_IDX_B_LOW:     rd_next = b_count_reg[7:0];
			`PFDIV_IDX_B_HIGH:    rd_next = {3'h0, b_count_reg[12:8]};
			`PFDIV_IDX_CNT_RESET: rd_next = {6'h00, ab_rst_reg, shared_rst_reg};
			`PFDIV_IDX_PRESCALER: rd_next = {1'b0, b_bypass_reg, 1'b0, pre_mode_reg, 2'h0};
			`PFDIV_IDX_REF_HIGH:  rd_next = {2'h0, ref_div_reg[13:8]};
			`PFDIV_IDX_REF_LOW:   rd_next = ref_div_reg[7:0];
			`PFDIV_IDX_INPUT_SEL: rd_next = {7'h00, input_sel_reg};
			default:              rd_next = 8'h00;
		endcase
	end

	// Read data captured in the waiting cycle, stands in the answer cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && bus_state_reg == BUS_IDLE) begin
			avs_readdata <= {24'h00_0000, rd_next};
		end
	end

	// ********************************
	// Configuration registers
	// ********************************
	// Register writes; only the low byte lane is implemented
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			input_sel_reg  <= `PFDIV_RST_INPUT_SEL;
			ref_div_reg    <= `PFDIV_RST_REF_DIV;
			pre_mode_reg   <= `PFDIV_RST_PRE_MODE;
			b_bypass_reg   <= 1'b0;
			a_count_reg    <= `PFDIV_RST_A_COUNT;
			b_count_reg    <= `PFDIV_RST_B_COUNT;
			shared_rst_reg <= 1'b0;
			ab_rst_reg     <= 1'b0;
		end else if (wr_take) begin
			case (word_idx)
				`PFDIV_IDX_A_COUNT:   a_count_reg <= avs_writedata[5:0];
				`PFDIV_IDX_B_LOW:     b_count_reg[7:0] <= avs_writedata[7:0];
				`PFDIV_IDX_B_HIGH:    b_count_reg[12:8] <= avs_writedata[4:0];
				`PFDIV_IDX_CNT_RESET: begin
					shared_rst_reg <= avs_writedata[`PFDIV_BIT_SHARED_RST];
					ab_rst_reg     <= avs_writedata[`PFDIV_BIT_AB_RST];
				end
				`PFDIV_IDX_PRESCALER: begin
					pre_mode_reg <= avs_writedata[`PFDIV_PRE_MODE_MSB:`PFDIV_PRE_MODE_LSB];
					b_bypass_reg <= avs_writedata[`PFDIV_BIT_B_BYPASS];
				end
				`PFDIV_IDX_REF_HIGH:  ref_div_reg[13:8] <= avs_writedata[5:0];
				`PFDIV_IDX_REF_LOW:   ref_div_reg[7:0] <= avs_writedata[7:0];
				`PFDIV_IDX_INPUT_SEL: input_sel_reg <= avs_writedata[`PFDIV_BIT_INPUT_SEL];
				default: ;
			endcase
		end
	end

	// ********************************
	// Input edges and distribution select
	// ********************************
	// Inputs are synchronous, so a one-flop delay finds rising edges
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ref_in_d_reg <= 1'b0;
			osc_in_d_reg <= 1'b0;
		end else begin
			ref_in_d_reg <= loop_source_input;
			osc_in_d_reg <= oscillator_feedback_input;
		end
	end
	assign ref_tick = loop_source_input & ~ref_in_d_reg;
	assign osc_tick = oscillator_feedback_input & ~osc_in_d_reg;

	// Distribution mux, registered to keep the output free of select glitches
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			dist_clock_out <= 1'b0;
		end else begin
			dist_clock_out <= input_sel_reg ? auxiliary_clock_input : oscillator_feedback_input;
		end
	end

	// ********************************
	// Reference divider
	// ********************************
	assign ref_cif.tick    = ref_tick;
	assign ref_cif.clear   = shared_rst_reg;
	assign ref_cif.modulus = ref_mod_sh_reg;

	// Ratio reloads at reset release, during shared reset or when a period closes, so no short pulse appears
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ref_mod_sh_reg <= 14'h0001;
			ref_load_reg   <= 1'b1;
		end else if (shared_rst_reg || ref_load_reg || ref_cif.done) begin
			ref_mod_sh_reg <= (ref_div_reg == 14'h0000) ? 14'h0001 : ref_div_reg;
			ref_load_reg   <= shared_rst_reg;
		end
	end

	pfdiv_counter u_ref_div (
		.clock  (clock),
		.resetn (resetn),
		.cif    (ref_cif)
	);

	// ********************************
	// Feedback divider: prescaler, A and B
	// ********************************
	// Decode prescaler code into P and mode kind
	always_comb begin
		p_next    = 6'h01;
		dual_next = 1'b0;
		case (pre_mode_reg)
			`PFDIV_MODE_FIX1:   p_next = 6'h01;
			`PFDIV_MODE_FIX2:   p_next = 6'h02;
			`PFDIV_MODE_DUAL2:  begin p_next = 6'h02; dual_next = 1'b1; end
			`PFDIV_MODE_DUAL4:  begin p_next = 6'h04; dual_next = 1'b1; end
			`PFDIV_MODE_DUAL8:  begin p_next = 6'h08; dual_next = 1'b1; end
			`PFDIV_MODE_DUAL16: begin p_next = 6'h10; dual_next = 1'b1; end
			`PFDIV_MODE_DUAL32: begin p_next = 6'h20; dual_next = 1'b1; end
			`PFDIV_MODE_FIX3:   p_next = 6'h03;
			default:          p_next = 6'h01;
		endcase
	end

	// Bypass forces B of one; software keeps bypass to fixed modes only
	assign b_mod_next = b_bypass_reg ? 14'h0001 : {1'b0, b_count_reg};
	assign fb_clear      = shared_rst_reg | ab_rst_reg;
	assign fb_period_end = b_cif.done;
	// Shadow copies load at reset release, counter reset or period end
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			p_sh_reg     <= 6'h01;
			dual_sh_reg  <= 1'b0;
			a_sh_reg     <= 6'h00;
			b_mod_sh_reg <= 14'h0000;
			fb_load_reg  <= 1'b1;
		end else if (fb_clear || fb_load_reg || fb_period_end) begin
			p_sh_reg     <= p_next;
			dual_sh_reg  <= dual_next;
			a_sh_reg     <= dual_next ? a_count_reg : 6'h00;
			b_mod_sh_reg <= b_mod_next;
			fb_load_reg  <= fb_clear;
		end
	end

	// A tally: P+1 cycles first, then P for the rest of the B period
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			a_left_reg <= 6'h00;
		end else if (fb_clear || fb_load_reg || fb_period_end) begin
			a_left_reg <= dual_next ? a_count_reg : 6'h00;
		end else if (pre_cif.done && a_left_reg != 6'h00) begin
			a_left_reg <= a_left_reg - 6'h01;
		end
	end

	// Prescaler counts oscillator edges only
	assign pre_cif.tick    = osc_tick;
	assign pre_cif.clear   = fb_clear | fb_load_reg;
	assign pre_cif.modulus = {8'h00, p_sh_reg} + {13'h0000, dual_sh_reg && a_left_reg != 6'h00};
	// B counts prescaler periods, giving N = P*B + A oscillator edges
	assign b_cif.tick    = pre_cif.done;
	assign b_cif.clear   = fb_clear | fb_load_reg;
	assign b_cif.modulus = b_mod_sh_reg;

	pfdiv_counter u_prescaler (
		.clock  (clock),
		.resetn (resetn),
		.cif    (pre_cif)
	);
	pfdiv_counter u_b_counter (
		.clock  (clock),
		.resetn (resetn),
		.cif    (b_cif)
	);

	// ********************************
	// Detector strobes
	// ********************************
	// One-cycle pulses toward the phase detector inputs
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ref_pfd_pulse <= 1'b0;
			fb_pfd_pulse  <= 1'b0;
		end else begin
			ref_pfd_pulse <= ref_cif.done;
			fb_pfd_pulse  <= fb_period_end;
		end
	end

	// ********************************
	// Assertions
	// ********************************
	property p_dist_sel;
		@(posedge clock) disable iff (!resetn)
		1'b1 |=> dist_clock_out == ($past(input_sel_reg) ? $past(auxiliary_clock_input)
			: $past(oscillator_feedback_input));
	endproperty
	a_dist_sel: assert property (p_dist_sel) else $error("distribution select wrong");
	property p_fb_from_osc;
		@(posedge clock) disable iff (!resetn)
		fb_pfd_pulse |-> $past(osc_tick);
	endproperty
	a_fb_from_osc: assert property (p_fb_from_osc) else $error("feedback pulse without osc edge");
	property p_ref_div_one;
		@(posedge clock) disable iff (!resetn)
		(ref_mod_sh_reg == 14'h0001 && ref_tick && !shared_rst_reg) |=> ref_pfd_pulse;
	endproperty
	a_ref_div_one: assert property (p_ref_div_one) else $error("ratio one did not pass edge");
	property p_zero_is_one;
		@(posedge clock) disable iff (!resetn)
		ref_mod_sh_reg != 14'h0000;
	endproperty
	a_zero_is_one: assert property (p_zero_is_one) else $error("reference ratio zero in use");
	property p_ref_low_wr;
		@(posedge clock) disable iff (!resetn)
		(wr_take && word_idx == `PFDIV_IDX_REF_LOW) |=> ref_div_reg[7:0] == $past(avs_writedata[7:0]);
	endproperty
	a_ref_low_wr: assert property (p_ref_low_wr) else $error("reference low byte not stored");
	property p_shared_hold;
		@(posedge clock) disable iff (!resetn)
		shared_rst_reg |=> !ref_pfd_pulse && !fb_pfd_pulse;
	endproperty
	a_shared_hold: assert property (p_shared_hold) else $error("pulse during shared reset");
	property p_ab_hold;
		@(posedge clock) disable iff (!resetn)
		ab_rst_reg |=> !fb_pfd_pulse;
	endproperty
	a_ab_hold: assert property (p_ab_hold) else $error("feedback pulse during A/B reset");
	property p_fixed_no_a;
		@(posedge clock) disable iff (!resetn)
		!dual_sh_reg |-> a_sh_reg == 6'h00 && a_left_reg == 6'h00 && pre_cif.modulus == {8'h00, p_sh_reg};
	endproperty
	a_fixed_no_a: assert property (p_fixed_no_a) else $error("A used in fixed mode");
	property p_bypass_b;
		@(posedge clock) disable iff (!resetn)
		(fb_period_end && b_bypass_reg && !fb_clear) |=> b_mod_sh_reg == 14'h0001;
	endproperty
	a_bypass_b: assert property (p_bypass_b) else $error("bypass did not give B of one");
	property p_shadow_stable;
		@(posedge clock) disable iff (!resetn)
		!(fb_clear || fb_load_reg || fb_period_end) |=> $stable(p_sh_reg) && $stable(b_mod_sh_reg);
	endproperty
	a_shadow_stable: assert property (p_shadow_stable) else $error("ratio changed mid period");
	property p_bus_answer;
		@(posedge clock) disable iff (!resetn)
		avs_waitrequest |=> (bus_req ##0 !avs_waitrequest) or !bus_req;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

	c_fb_dual: cover property (@(posedge clock) disable iff (!resetn) fb_pfd_pulse && dual_sh_reg);
	c_ref_div: cover property (@(posedge clock) disable iff (!resetn) ref_pfd_pulse && ref_mod_sh_reg > 14'h0001);
	c_bypass:  cover property (@(posedge clock) disable iff (!resetn) fb_pfd_pulse && b_mod_sh_reg == 14'h0001);
	c_wr:      cover property (@(posedge clock) disable iff (!resetn) wr_take);
endmodule // pfdiv_top

// >>> core/pfdiv_regs.svh
// Register indices, field positions, prescaler mode encodings and reset values of the loop dividers
`ifndef PFDIV_REGS_SVH
`define PFDIV_REGS_SVH

// ********************************
// Register indices (byte address = 4 x index)
// ********************************
`define PFDIV_IDX_STATUS      8'h01
`define PFDIV_IDX_A_COUNT     8'h04
`define PFDIV_IDX_B_LOW       8'h05
`define PFDIV_IDX_B_HIGH      8'h06
`define PFDIV_IDX_CNT_RESET   8'h09
`define PFDIV_IDX_PRESCALER   8'h0a
`define PFDIV_IDX_REF_HIGH    8'h0b
`define PFDIV_IDX_REF_LOW     8'h0c
`define PFDIV_IDX_INPUT_SEL   8'h45

// ********************************
// Field positions
// ********************************
`define PFDIV_BIT_SHARED_RST  0
`define PFDIV_BIT_AB_RST      1
`define PFDIV_PRE_MODE_LSB    2
`define PFDIV_PRE_MODE_MSB    4
`define PFDIV_BIT_B_BYPASS    6
`define PFDIV_BIT_INPUT_SEL   0

// ********************************
// Prescaler mode encodings
// ********************************
`define PFDIV_MODE_FIX1       3'h0
`define PFDIV_MODE_FIX2       3'h1
`define PFDIV_MODE_DUAL2      3'h2
`define PFDIV_MODE_DUAL4      3'h3
`define PFDIV_MODE_DUAL8      3'h4
`define PFDIV_MODE_DUAL16     3'h5
`define PFDIV_MODE_DUAL32     3'h6
`define PFDIV_MODE_FIX3       3'h7

// ********************************
// Reset values
// ********************************
`define PFDIV_RST_INPUT_SEL   1'b1
`define PFDIV_RST_REF_DIV     14'h0000
`define PFDIV_RST_B_COUNT     13'h0000
`define PFDIV_RST_A_COUNT     6'h00
`define PFDIV_RST_PRE_MODE    3'h0

`endif

// >>> core/pfdiv_pkg.sv
// Types shared by the loop divider modules
package pfdiv_pkg;
	typedef logic [13:0] pfdiv_cnt_t;                 // Common counter / modulus width
	typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} pfdiv_bus_state_t;   // Bus answer phases
endpackage

// >>> core/pfdiv_cnt_if.sv
// Handshake between a divider owner and one edge counter
`timescale 1ns/100ps
interface pfdiv_cnt_if;
	import pfdiv_pkg::*;
	logic       tick;       // One counted input edge
	logic       clear;      // Hold count at zero
	pfdiv_cnt_t modulus;    // Division ratio, 0 and 1 both divide by one
	logic       done;       // Terminal edge of the current period
	modport owner   (output tick, output clear, output modulus, input done);
	modport counter (input tick, input clear, input modulus, output done);
endinterface

// >>> core/pfdiv_counter.sv
// Generic edge counter that flags every modulus-th tick
`timescale 1ns/100ps
module pfdiv_counter
	import pfdiv_pkg::*;
(
	input  wire logic  clock,
	input  wire logic  resetn,
	pfdiv_cnt_if.counter cif
);
	pfdiv_cnt_t count_reg;   // Ticks seen in this period
	logic       terminal;    // Current tick closes the period

	// Ratio 0 behaves as 1 so a blank setting still passes edges
	assign terminal = (cif.modulus <= 14'h0001) || (count_reg == cif.modulus - 14'h0001);
	assign cif.done = cif.tick & terminal & ~cif.clear;

	// Count ticks, wrap at the terminal tick
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			count_reg <= 14'h0000;
		end else if (cif.clear) begin
			count_reg <= 14'h0000;
		end else if (cif.tick) begin
			count_reg <= terminal ? 14'h0000 : count_reg + 14'h0001;
		end
	end
endmodule // pfdiv_counter

// >>> verif/pfdiv_source_model.sv
// Behavioural reference source, oscillator and auxiliary clock driving the loop dividers
`timescale 1ns/100ps
module pfdiv_source_model (
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic ref_en,
	input  wire logic osc_en,
	output logic      loop_source_input,
	output logic      oscillator_feedback_input,
	output logic      auxiliary_clock_input,
	output int        ref_edges,
	output int        osc_edges
);
	logic [1:0] ref_ph; // Phase inside a four-cycle reference period
	logic [1:0] osc_ph; // Phase inside a four-cycle oscillator period
	logic [1:0] aux_ph; // Divider for the free-running auxiliary clock

	// Reference bursts: one rising edge per four clocks, stands low when idle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ref_ph <= 2'h0;
			loop_source_input <= 1'b0;
			ref_edges <= 0;
		end else begin
			if (ref_ph != 2'h0 || ref_en)
				ref_ph <= ref_ph + 2'h1;
			loop_source_input <= (ref_ph == 2'h0 && ref_en) || ref_ph == 2'h1;
			if (ref_ph == 2'h0 && ref_en)
				ref_edges <= ref_edges + 1;
		end
	end

	// Oscillator bursts; a period is always finished so no runt pulse reaches the divider
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			osc_ph <= 2'h0;
			oscillator_feedback_input <= 1'b0;
			osc_edges <= 0;
		end else begin
			if (osc_ph != 2'h0 || osc_en)
				osc_ph <= osc_ph + 2'h1;
			oscillator_feedback_input <= (osc_ph == 2'h0 && osc_en) || osc_ph == 2'h1;
			if (osc_ph == 2'h0 && osc_en)
				osc_edges <= osc_edges + 1;
		end
	end

	// Auxiliary clock runs free, toggling every third clock
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			aux_ph <= 2'h0;
			auxiliary_clock_input <= 1'b0;
		end else if (aux_ph == 2'h2) begin
			aux_ph <= 2'h0;
			auxiliary_clock_input <= ~auxiliary_clock_input;
		end else begin
			aux_ph <= aux_ph + 2'h1;
		end
	end
endmodule // pfdiv_source_model

// >>> verif/tb_pfdiv_top.sv
// Self-checking bench for the reference and feedback dividers
`timescale 1ns/100ps
module tb_pfdiv_top;
	logic        clock, resetn;             // 20 MHz clock, active-low reset
	logic [9:0]  avs_address;               // Bus byte address
	logic        avs_read, avs_write;       // Bus strobes
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  avs_byteenable;
	logic        avs_waitrequest;
	logic        ref_en, osc_en;            // Burst enables for the sources
	logic        src_ref, src_osc, src_aux; // Source pins
	logic        ref_pfd_pulse, fb_pfd_pulse, dist_clock_out;
	logic [31:0] rd;                        // Last read data
	int          ref_edges, osc_edges, ref_pulses, fb_pulses, cycles, errors, tests_run;
	// Register table: index, reset value, writable mask (last entry unmapped)
	logic [7:0]  reg_idx [9] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h45, 8'h04, 8'h05, 8'h06, 8'h02};
	logic [7:0]  reg_rst [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  reg_msk [9] = '{8'h03, 8'h5c, 8'h3f, 8'hff, 8'h01, 8'h3f, 8'hff, 8'h1f, 8'h00};

	pfdiv_top uut (.clock(clock), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .loop_source_input(src_ref),
		.oscillator_feedback_input(src_osc), .auxiliary_clock_input(src_aux),
		.ref_pfd_pulse(ref_pfd_pulse), .fb_pfd_pulse(fb_pfd_pulse), .dist_clock_out(dist_clock_out));
	pfdiv_source_model src (.clock(clock), .resetn(resetn), .ref_en(ref_en), .osc_en(osc_en),
		.loop_source_input(src_ref), .oscillator_feedback_input(src_osc),
		.auxiliary_clock_input(src_aux), .ref_edges(ref_edges), .osc_edges(osc_edges));

	// ****************
	// Clock, pulse counters and hang guard
	// ****************
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Pulses stand one cycle, so each is seen at exactly one edge
	always @(posedge clock) begin
		if (ref_pfd_pulse === 1'b1) ref_pulses++;
		if (fb_pfd_pulse === 1'b1) fb_pulses++;
		cycles++;
		if (cycles == 40000) begin
			errors++;
			test_done();
		end
	end

	// ****************
	// Shared tasks
	// ****************
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Request is held until waitrequest is seen low at a rising edge
	task bus_op(input logic wr, input logic [7:0] idx, input logic [7:0] data, input logic [3:0] be);
		@(posedge clock);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h0, data};
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= ~wr;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task wr(input logic [7:0] idx, input logic [7:0] data);
		bus_op(1'b1, idx, data, 4'hf);
	endtask
	// Exact edge bursts, then the pulse counts they caused; a negative count is not judged
	task burst(input int nr, input int no, input int er, input int ef);
		int r0, o0, rp, fp;
		r0 = ref_edges; o0 = osc_edges; rp = ref_pulses; fp = fb_pulses;
		ref_en <= (nr > 0);
		osc_en <= (no > 0);
		do begin
			@(posedge clock);
			if (ref_edges - r0 >= nr) ref_en <= 1'b0;
			if (osc_edges - o0 >= no) osc_en <= 1'b0;
		end while (ref_edges - r0 < nr || osc_edges - o0 < no);
		repeat (6) @(posedge clock);
		if (er >= 0) check("ref pulses", 32'(ref_pulses - rp), 32'(er));
		if (ef >= 0) check("fb pulses", 32'(fb_pulses - fp), 32'(ef));
	endtask

	// ****************
	// Scenarios
	// ****************
	task test_registers();
		for (int i = 0; i < 9; i++) begin
			bus_op(1'b0, reg_idx[i], 8'h00, 4'hf);
			check("reset value", rd, {24'h0, reg_rst[i]});
			wr(reg_idx[i], 8'hff);
			bus_op(1'b0, reg_idx[i], 8'h00, 4'hf);
			check("readback", rd, {24'h0, reg_msk[i]});
			wr(reg_idx[i], reg_rst[i]);
		end
		bus_op(1'b1, 8'h45, 8'h00, 4'h0);
		bus_op(1'b0, 8'h45, 8'h00, 4'hf);
		check("lane off write", rd, 32'h1);
	endtask
	// Ratio r: one pulse after 2r-1 edges, the second on the next edge
	task ref_case(input logic [7:0] hi, input logic [7:0] lo, input int r);
		wr(8'h09, 8'h01);
		wr(8'h0b, hi);
		wr(8'h0c, lo);
		wr(8'h09, 8'h00);
		burst(2 * r - 1, 0, 1, -1);
		burst(1, 0, 1, -1);
	endtask
	task test_reference();
		ref_case(8'h00, 8'h00, 1);
		ref_case(8'h01, 8'h03, 259);
		ref_case(8'h00, 8'h05, 5);
		burst(2, 0, 0, -1);
		// Ratio change two edges into a period must not cut that period short
		wr(8'h0c, 8'h02);
		burst(3, 0, 1, -1);
		burst(2, 0, 1, -1);
	endtask
	// Software keeps B in 3..8191 unless bypassed, bypasses only in fixed modes
	task fb_case(input logic [2:0] m, input logic [5:0] a, input logic [12:0] b, input logic byp, input int n);
		wr(8'h09, 8'h01);
		wr(8'h04, {2'h0, a});
		wr(8'h05, b[7:0]);
		wr(8'h06, {3'h0, b[12:8]});
		wr(8'h0a, {1'b0, byp, 1'b0, m, 2'b00});
		wr(8'h09, 8'h00);
		burst(0, 2 * n - 1, -1, 1);
		burst(0, 1, -1, 1);
	endtask
	task test_feedback();
		fb_case(3'h0, 6'h00, 13'h0000, 1'b1, 1);
		fb_case(3'h1, 6'h00, 13'h0000, 1'b1, 2);
		fb_case(3'h1, 6'h07, 13'h0003, 1'b0, 6);
		fb_case(3'h7, 6'h05, 13'h0003, 1'b0, 9);
		fb_case(3'h0, 6'h00, 13'h0105, 1'b0, 261);
		fb_case(3'h2, 6'h3f, 13'h0040, 1'b0, 191);
		// Source stays far below every dual-modulus input limit
		for (int m = 2; m <= 6; m++)
			fb_case(m[2:0], 6'h02, 13'h0003, 1'b0, 3 * (1 << (m - 1)) + 2);
	endtask
	task test_resets();
		ref_case(8'h00, 8'h00, 1);
		wr(8'h0a, 8'h40);
		wr(8'h09, 8'h02);
		burst(3, 3, 3, 0);
		wr(8'h09, 8'h01);
		burst(3, 3, 0, 0);
		wr(8'h09, 8'h00);
		burst(3, 0, 3, 0);
		burst(0, 3, 0, 3);
	endtask
	// Distribution output follows the selected input one cycle late
	task dist_check(input logic sel);
		logic prev;
		wr(8'h45, {7'h0, sel});
		osc_en <= 1'b1;
		repeat (3) @(posedge clock);
		repeat (12) begin
			@(posedge clock);
			prev = sel ? src_aux : src_osc;
			@(negedge clock);
			check("dist clock", {31'h0, dist_clock_out}, {31'h0, prev});
		end
		@(posedge clock);
		osc_en <= 1'b0;
		repeat (6) @(posedge clock);
	endtask

	task test_done();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		resetn = 1'b0;
		avs_address = 10'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
		ref_en = 1'b0;
		osc_en = 1'b0;
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		test_registers();
		test_reference();
		test_feedback();
		test_resets();
		dist_check(1'b1);
		dist_check(1'b0);
		test_done();
	end
endmodule // tb_pfdiv_top
